/* File: wdog_defines.vh */
// constants for the channel watchdog and missed-frame block
// assumes inclusion by bare name from the design files
`ifndef WDOG_DEFINES_VH
`define WDOG_DEFINES_VH
`define ADDR_TIMEOUT_LIMITS 32'h20008024
`define ADDR_REV_MISSED 32'h2000802C
`define RX_FIELD_HI 31
`define RX_FIELD_LO 16
`define TX_FIELD_HI 15
`define TX_FIELD_LO 0
`define REV_FIELD_HI 20
`define REV_FIELD_LO 16
`define MISSED_FIELD_HI 15
`define MISSED_FIELD_LO 0
`define TIMEOUT_DEFAULT 16'h04E2
`define TIMEOUT_FLOOR 16'h002D
`define TIMEOUT_LOW_MAX 16'h002C
`define SER_PER_UNIT 5'h10
// revision value is arbitrary
`define CHIP_REVISION 5'h05
`endif

/* File: pin_sync3.v */
// three-stage synchroniser with agreement filter
// assumes async input, clk domain, clock enable gates all state
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 (
   input wire clk,
   input wire nrst,
   input wire ce,
   input wire din,
   output reg dout
);
   reg s1_r;
   reg s2_r;
   reg s3_r;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         dout <= 1'b0;
      end else if (ce) begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // change counts once stages two and three agree
         if (s2_r == s3_r) begin
            dout <= s3_r;
         end
      end
   end
endmodule
`default_nettype wire

/* File: chan_watchdog.v */
// one channel watchdog: counts serial ticks while active
// assumes ser_tick is a one-cycle pulse per serial-clock cycle
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defines.vh"
module chan_watchdog (
   input wire clk,
   input wire nrst,
   input wire ce,
   input wire active,
   input wire ser_tick,
   input wire [15:0] limit,
   output reg expire
);
   reg [3:0] sub_r;
   reg [15:0] units_r;
   reg active_d_r;
   wire [15:0] eff_limit;
   // short limits are raised to the floor
   assign eff_limit = (limit != 16'h0000 && limit <= `TIMEOUT_LOW_MAX) ? `TIMEOUT_FLOOR : limit; // R7 R8
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sub_r <= 4'h0;
         units_r <= 16'h0000;
         active_d_r <= 1'b0;
         expire <= 1'b0;
      end else if (ce) begin
         active_d_r <= active;
         expire <= 1'b0;
         if (!active || !active_d_r) begin
            sub_r <= 4'h0; // R17
            units_r <= 16'h0000;
         end else if (ser_tick && limit != 16'h0000) begin // R3
            sub_r <= sub_r + 4'h1;
            if (sub_r == 4'hF) begin
               if (units_r + 16'h0001 >= eff_limit) begin
                  expire <= 1'b1; // R1 R2
                  units_r <= 16'h0000;
               end else begin
                  units_r <= units_r + 16'h0001;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

/* File: net_ctrl_watchdog.v */
// watchdog timers and revision/missed-frame register of the network controller
// assumes a longword register port on clk, serial clock sampled as a pin
// Contract
// R1: a receiver active for receive limit times 16 serial cycles is cut off and flagged.
// R2: a transmitter active for transmit limit times 16 serial cycles is cut off and flagged.
// R3: a limit of zero disables that watchdog.
// R4: hardware and software reset load both limits with 1250.
// R5: the receive limit is changed only while reception is stopped.
// R6: the transmit limit is changed only while transmission is stopped.
// R7: a receive limit of 1 to 44 acts as 45.
// R8: a transmit limit of 1 to 44 acts as 45.
// R9: the receive limit sits in bits 31 to 16 as an unsigned count.
// R10: the transmit limit sits in bits 15 to 0 as an unsigned count.
// R11: frames dropped for lack of a receive buffer are counted in bits 15 to 0 of the statistics register.
// R12: reading the statistics register returns the count and clears it.
// R13: bits 20 to 16 of the statistics register hold a fixed revision number.
// R14: bits 31 to 21 of the statistics register read as zero.
// R15: writes to the statistics register change nothing.
// R16: a limit write while its process runs is dropped.
// R17: each watchdog restarts from zero at activity start and stops when it ends.
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defines.vh"
module net_ctrl_watchdog (
   // clock and reset
   input wire clk,
   input wire nrst,
   input wire ce,
   input wire soft_rst,
   // register port
   input wire reg_sel,
   input wire reg_wr,
   input wire [31:0] reg_addr,
   input wire [31:0] reg_wdata,
   output reg [31:0] reg_rdata,
   output reg reg_ack,
   // process state
   input wire rx_stopped,
   input wire tx_stopped,
   input wire rx_active,
   input wire tx_active,
   input wire frame_missed,
   // serial clock pin
   input wire ser_clk,
   // watchdog outcomes
   output reg rx_cutoff,
   output reg tx_cutoff,
   output reg rx_watchdog_flag,
   output reg transmit_watchdog_flag
);
   // limit fields and their next values
   reg [15:0] receive_timeout_count_r;
   reg [15:0] receive_timeout_count_nxt;
   reg [15:0] transmit_timeout_count_r;
   reg [15:0] transmit_timeout_count_nxt;
   // missed-frame count
   reg [15:0] missed_frame_counter_r;
   reg [15:0] missed_frame_counter_nxt;
   // register port answer
   reg [31:0] rdata_nxt;
   reg ack_nxt;
   // channel outcomes
   reg rx_cutoff_nxt;
   reg tx_cutoff_nxt;
   reg rx_flag_nxt;
   reg tx_flag_nxt;
   // serial clock edge
   reg ser_d_r;
   wire ser_s;
   wire ser_tick;
   // watchdog side
   wire rx_run;
   wire tx_run;
   wire rx_exp;
   wire tx_exp;
   wire rx_hit;
   wire tx_hit;
   // register decode
   wire wr_lim;
   wire rx_take;
   wire tx_take;
   wire rd_stat;
   wire missed_full;
   wire [15:0] missed_inc;
   wire [31:0] lim_word;
   wire [31:0] stat_word;
   // revision value is arbitrary
   localparam [4:0] CHIP_REV = `CHIP_REVISION;

   // serial pin is asynchronous to clk, so it is filtered before any edge is taken
   pin_sync3 u_ser (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .din(ser_clk),
      .dout(ser_s)
   );

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ser_d_r <= 1'b0;
      end else if (ce) begin
         ser_d_r <= ser_s;
      end
   end

   // one tick per rising serial edge; reset low like the idle pin, so no false tick
   assign ser_tick = ser_s & ~ser_d_r;

   // a cut channel looks idle to its watchdog, so its count restarts
   assign rx_run = rx_active & ~rx_cutoff;
   assign tx_run = tx_active & ~tx_cutoff;

   chan_watchdog u_rx (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .active(rx_run),
      .ser_tick(ser_tick),
      .limit(receive_timeout_count_r),
      .expire(rx_exp)
   );

   chan_watchdog u_tx (
      .clk(clk),
      .nrst(nrst),
      .ce(ce),
      .active(tx_run),
      .ser_tick(ser_tick),
      .limit(transmit_timeout_count_r),
      .expire(tx_exp)
   );

   // an expiry that lands after the channel dropped is ignored
   assign rx_hit = rx_exp & rx_active; // R1
   assign tx_hit = tx_exp & tx_active; // R2

   // one longword register each, exact address match
   assign wr_lim = reg_sel & reg_wr & (reg_addr == `ADDR_TIMEOUT_LIMITS);
   assign rx_take = wr_lim & rx_stopped; // R5 R16
   assign tx_take = wr_lim & tx_stopped; // R6 R16
   assign rd_stat = reg_sel & ~reg_wr & (reg_addr == `ADDR_REV_MISSED); // R12 R15
   assign missed_full = (missed_frame_counter_r == 16'hFFFF);
   assign missed_inc = missed_frame_counter_r + 16'h0001;
   assign lim_word = {receive_timeout_count_r, transmit_timeout_count_r}; // R9 R10
   assign stat_word = {11'h000, CHIP_REV, missed_frame_counter_r}; // R13 R14

   // receive limit: soft reset first, then a write taken while stopped
   always @* begin
      receive_timeout_count_nxt = receive_timeout_count_r;
      if (soft_rst) begin
         receive_timeout_count_nxt = `TIMEOUT_DEFAULT; // R4
      end else if (rx_take) begin
         receive_timeout_count_nxt = reg_wdata[`RX_FIELD_HI:`RX_FIELD_LO]; // R5 R9
      end
   end

   // transmit limit, gated on its own process only
   always @* begin
      transmit_timeout_count_nxt = transmit_timeout_count_r;
      if (soft_rst) begin
         transmit_timeout_count_nxt = `TIMEOUT_DEFAULT; // R4
      end else if (tx_take) begin
         transmit_timeout_count_nxt = reg_wdata[`TX_FIELD_HI:`TX_FIELD_LO]; // R6 R10
      end
   end

   // hardware reset loads the same default as soft reset
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         receive_timeout_count_r <= `TIMEOUT_DEFAULT; // R4
      end else if (ce) begin
         receive_timeout_count_r <= receive_timeout_count_nxt;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         transmit_timeout_count_r <= `TIMEOUT_DEFAULT; // R4
      end else if (ce) begin
         transmit_timeout_count_r <= transmit_timeout_count_nxt;
      end
   end

   // count saturates rather than wrap, so a stale read never shows a small number
   always @* begin
      missed_frame_counter_nxt = missed_frame_counter_r;
      if (soft_rst) begin
         missed_frame_counter_nxt = 16'h0000;
      end else if (rd_stat) begin
         // a miss in the read cycle starts the new count
         missed_frame_counter_nxt = frame_missed ? 16'h0001 : 16'h0000; // R12
      end else if (frame_missed && !missed_full) begin
         missed_frame_counter_nxt = missed_inc; // R11
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         missed_frame_counter_r <= 16'h0000;
      end else if (ce) begin
         missed_frame_counter_r <= missed_frame_counter_nxt;
      end
   end

   // unmapped reads and every write answer with zero data
   always @* begin
      rdata_nxt = 32'h00000000;
      if (reg_sel && !reg_wr) begin
         case (reg_addr)
            `ADDR_TIMEOUT_LIMITS: begin
               rdata_nxt = lim_word;
            end
            `ADDR_REV_MISSED: begin
               rdata_nxt = stat_word; // R12
            end
            default: begin
               rdata_nxt = 32'h00000000;
            end
         endcase
      end
   end

   // every access is answered one cycle later, mapped or not
   always @* begin
      ack_nxt = reg_sel;
   end

   // read data stands for one cycle only, then returns to zero
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 32'h00000000;
      end else if (ce) begin
         reg_rdata <= rdata_nxt;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         reg_ack <= 1'b0;
      end else if (ce) begin
         reg_ack <= ack_nxt;
      end
   end

   // flags are single-cycle pulses; the sticky status bit lives elsewhere
   always @* begin
      rx_flag_nxt = rx_hit; // R1
   end

   always @* begin
      tx_flag_nxt = tx_hit; // R2
   end

   // cut holds until the channel drops its activity
   always @* begin
      rx_cutoff_nxt = rx_cutoff;
      if (rx_hit) begin
         rx_cutoff_nxt = 1'b1; // R1
      end else if (!rx_active) begin
         rx_cutoff_nxt = 1'b0; // R17
      end
   end

   always @* begin
      tx_cutoff_nxt = tx_cutoff;
      if (tx_hit) begin
         tx_cutoff_nxt = 1'b1; // R2
      end else if (!tx_active) begin
         tx_cutoff_nxt = 1'b0; // R17
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_watchdog_flag <= 1'b0;
      end else if (ce) begin
         rx_watchdog_flag <= rx_flag_nxt;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         transmit_watchdog_flag <= 1'b0;
      end else if (ce) begin
         transmit_watchdog_flag <= tx_flag_nxt;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rx_cutoff <= 1'b0;
      end else if (ce) begin
         rx_cutoff <= rx_cutoff_nxt;
      end
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_cutoff <= 1'b0;
      end else if (ce) begin
         tx_cutoff <= tx_cutoff_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: ser_line.sv */
// serial clock source standing in for the network side
// assumes en is driven just after a clk edge
`timescale 1ns/1ps
`default_nettype none
module ser_line (
   // control
   input wire logic en,
   // serial clock
   output logic ser_clk
);
   // still and low outside traffic
   initial ser_clk = 1'b0;
   always begin
      wait (en);
      #160 ser_clk = 1'b1;
      #160 ser_clk = 1'b0;
   end
endmodule
`default_nettype wire

/* File: net_ctrl_watchdog_asserts.sv */
// port assertions for the watchdog block
// assumes ce held high by the bench
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defines.vh"
module net_ctrl_watchdog_asserts (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port
   input wire logic reg_sel,
   input wire logic reg_wr,
   input wire logic [31:0] reg_addr,
   input wire logic [31:0] reg_rdata,
   input wire logic reg_ack,
   // channels
   input wire logic tx_active,
   input wire logic tx_cutoff,
   input wire logic transmit_watchdog_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_stat_rd;
      reg_sel && !reg_wr && reg_addr == `ADDR_REV_MISSED;
   endsequence
   sequence s_tx_idle;
      !tx_active [*2];
   endsequence
   AST_ACK: assert property (reg_sel |=> reg_ack)
      else $error("missing ack");
   AST_NO_ACK: assert property (!reg_sel |=> !reg_ack)
      else $error("stray ack");
   AST_WR_ZERO: assert property (reg_sel && reg_wr |=> reg_rdata == 32'h0)
      else $error("data on write");
   AST_REV: assert property (s_stat_rd |=> reg_rdata[20:16] == `CHIP_REVISION)
      else $error("bad revision");
   AST_ZERO_BITS: assert property (s_stat_rd |=> reg_rdata[31:21] == 11'h000)
      else $error("reserved bits set");
   AST_TX_CUT: assert property (transmit_watchdog_flag |-> tx_cutoff && $past(tx_active))
      else $error("flag without cutoff");
   AST_TX_PULSE: assert property (transmit_watchdog_flag |=> !transmit_watchdog_flag)
      else $error("flag too long");
   AST_TX_REL: assert property (s_tx_idle |-> !tx_cutoff)
      else $error("cutoff held");
endmodule
bind net_ctrl_watchdog net_ctrl_watchdog_asserts net_ctrl_watchdog_asserts_i (.clk(clk), .nrst(nrst),
   .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
   .tx_active(tx_active), .tx_cutoff(tx_cutoff), .transmit_watchdog_flag(transmit_watchdog_flag));
`default_nettype wire

/* File: tb.sv */
// bench for the watchdog block
// assumes design files and ser_line
`timescale 1ns/1ps
`default_nettype none
`include "wdog_defines.vh"
module tb;
   logic clk, nrst, soft_rst, reg_sel, reg_wr, rx_stopped, tx_stopped, rx_active, tx_active, frame_missed;
   logic ser_en, ser_clk, reg_ack, rx_cutoff, tx_cutoff, rxf, txf;
   logic [31:0] reg_addr, reg_wdata, reg_rdata, rd;
   int mismatches, total_checks, n, rxn;
   net_ctrl_watchdog net_ctrl_watchdog_i (.clk(clk), .nrst(nrst), .ce(1'b1), .soft_rst(soft_rst),
      .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .rx_stopped(rx_stopped), .tx_stopped(tx_stopped), .rx_active(rx_active),
      .tx_active(tx_active), .frame_missed(frame_missed), .ser_clk(ser_clk), .rx_cutoff(rx_cutoff),
      .tx_cutoff(tx_cutoff), .rx_watchdog_flag(rxf), .transmit_watchdog_flag(txf));
   ser_line ser_line_i (.en(ser_en), .ser_clk(ser_clk));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask
   task acc(input logic w, input logic [31:0] a, input logic [31:0] d);
      reg_sel = 1'b1;
      reg_wr = w;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1;
      reg_sel = 1'b0;
      rd = reg_rdata;
      chk("ack", 32'h1, {31'h0, reg_ack});
      @(posedge clk);
      #1;
   endtask
   task t_limits;
      acc(0, `ADDR_TIMEOUT_LIMITS, 32'h0);
      chk("reset limits", 32'h04E204E2, rd);
      acc(0, 32'h20008028, 32'h0);
      chk("unmapped", 32'h0, rd);
      acc(1, `ADDR_TIMEOUT_LIMITS, 32'h00000002);
      rx_stopped = 1'b0;
      acc(1, `ADDR_TIMEOUT_LIMITS, 32'hFFFF0005);
      rx_stopped = 1'b1;
      tx_stopped = 1'b0;
      acc(1, `ADDR_TIMEOUT_LIMITS, 32'h00000009);
      tx_stopped = 1'b1;
      acc(0, `ADDR_TIMEOUT_LIMITS, 32'h0);
      chk("gated limits", 32'h00000005, rd);
   endtask
   task t_timers;
      ser_en = 1'b1;
      rx_active = 1'b1;
      tx_active = 1'b1;
      n = 0;
      rxn = 0;
      while (txf !== 1'b1 && n < 8000) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= 8000) begin
         mismatches++;
         test_done;
      end
      // 45 units of 16 serial cycles, 8 clocks each
      chk("tx expiry", 32'h1, {31'h0, n > 5750 && n < 5790});
      chk("tx cut", 32'h1, {31'h0, tx_cutoff});
      tx_active = 1'b0;
      repeat (600) begin
         @(posedge clk);
         #1;
         if (rxf !== 1'b0 || rx_cutoff !== 1'b0) rxn++;
      end
      chk("rx disabled", 32'h0, rxn);
      rx_active = 1'b0;
      ser_en = 1'b0;
   endtask
   task t_missed;
      repeat (3) begin
         frame_missed = 1'b1;
         @(posedge clk);
         #1;
         frame_missed = 1'b0;
         @(posedge clk);
         #1;
      end
      acc(1, `ADDR_REV_MISSED, 32'hFFFFFFFF);
      acc(0, `ADDR_REV_MISSED, 32'h0);
      chk("missed", {11'h000, `CHIP_REVISION, 16'h0003}, rd);
      acc(0, `ADDR_REV_MISSED, 32'h0);
      chk("cleared", {11'h000, `CHIP_REVISION, 16'h0000}, rd);
      soft_rst = 1'b1;
      @(posedge clk);
      #1;
      soft_rst = 1'b0;
      acc(0, `ADDR_TIMEOUT_LIMITS, 32'h0);
      chk("soft limits", 32'h04E204E2, rd);
   endtask
   task t_rx;
      acc(1, `ADDR_TIMEOUT_LIMITS, 32'h00010000);
      ser_en = 1'b1;
      rx_active = 1'b1;
      tx_active = 1'b1;
      n = 0;
      rxn = 0;
      while (rxf !== 1'b1 && n < 8000) begin
         @(posedge clk);
         #1;
         n++;
         if (txf !== 1'b0 || tx_cutoff !== 1'b0) rxn++;
      end
      if (n >= 8000) begin
         mismatches++;
         test_done;
      end
      // a limit of 1 acts as 45 units
      chk("rx expiry", 32'h1, {31'h0, n > 5750 && n < 5790});
      chk("rx cut", 32'h1, {31'h0, rx_cutoff});
      rx_active = 1'b0;
      repeat (2) begin
         @(posedge clk);
         #1;
      end
      chk("rx release", 32'h0, {31'h0, rx_cutoff});
      repeat (600) begin
         @(posedge clk);
         #1;
         if (txf !== 1'b0 || tx_cutoff !== 1'b0) rxn++;
      end
      chk("tx disabled", 32'h0, rxn);
      tx_active = 1'b0;
      ser_en = 1'b0;
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      {nrst, soft_rst, reg_sel, reg_wr, rx_active, tx_active, frame_missed, ser_en} = 8'h00;
      {rx_stopped, tx_stopped} = 2'h3;
      reg_addr = 32'h0;
      reg_wdata = 32'h0;
      repeat (5) @(posedge clk);
      #1;
      nrst = 1'b1;
      t_limits;
      t_timers;
      t_missed;
      t_rx;
      test_done;
   end
endmodule
`default_nettype wire
